// *** src/tfg_fault_if.sv ***
/*
 carrier between the fault guard top and its input sampler.
 assumes both ends share clock_in.
*/
`timescale 1ns/100ps
interface tfg_fault_if;
   logic raw_level;   // selected fault source level
   logic filt_en;     // noise filter inserted
   logic rise_sel;    // 1 = rising edge qualifies, 0 = falling
   logic event_hit;   // qualifying edge seen, one-cycle pulse

   modport ctrl
   (
      output raw_level,
      output filt_en,
      output rise_sel,
      input  event_hit
   );
   modport smp
   (
      input  raw_level,
      input  filt_en,
      input  rise_sel,
      output event_hit
   );
endinterface

// *** src/tfg_fault_sampler.sv ***
/*
 fault input sampler: two-stage synchroniser, optional four-sample
 noise filter and edge detector, all on the system clock.
 assumes the selected source level arrives through the interface.
*/
`timescale 1ns/100ps
module tfg_fault_sampler
   import tfg_pkg::*;
(
   // clock and reset
   input  wire logic clock_in,
   input  wire logic reset_in,
   // fault path
   tfg_fault_if.smp  fault_if
);

   // ==========================================================
   // storage
   // ==========================================================
   logic                sync1_r;   // first synchroniser stage
   logic                sync2_r;   // second synchroniser stage
   logic [FILT_LEN-2:0] hist_r;    // older samples for the filter
   logic                filt_r;    // filtered level
   logic                prev_r;    // last level seen by edge detector
   logic                level;     // level fed to edge detector
   logic                agree_hi;  // all samples high
   logic                agree_lo;  // all samples low

   // synchroniser, first stage only feeds the second
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end
      else
      begin
         sync1_r <= fault_if.raw_level;
         sync2_r <= sync1_r;
      end
   end

   // agreement of the current and three older samples
   assign agree_hi = &{hist_r, sync2_r};
   assign agree_lo = ~|{hist_r, sync2_r};

   // filter runs on every system clock, prescaler has no say
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         hist_r <= '0;
         filt_r <= 1'b0;
      end
      else
      begin
         hist_r <= {hist_r[FILT_LEN-3:0], sync2_r};
         if (agree_hi)
         begin
            filt_r <= 1'b1;
         end
         else if (agree_lo)
         begin
            filt_r <= 1'b0;
         end
      end
   end

   // filter inserted ahead of the edge detector when enabled
   assign level = fault_if.filt_en ? filt_r : sync2_r;

   // edge detector
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         prev_r <= 1'b0;
      end
      else
      begin
         prev_r <= level;
      end
   end

   // toggling source or filter may itself make an edge here, toggling edge select alone cannot
   assign fault_if.event_hit = (level != prev_r) && (level == fault_if.rise_sel);

   // ==========================================================
   // assertions
   // ==========================================================
   property p_filter_agree;
      @(posedge clock_in) disable iff (reset_in)
      $changed(filt_r) |-> $past(agree_hi) || $past(agree_lo);
   endproperty
   a_filter_agree: assert property (p_filter_agree)
      else $error("filter output changed without four equal samples");

   property p_filter_delay;
      @(posedge clock_in) disable iff (reset_in)
      (fault_if.filt_en && $rose(sync2_r) && !filt_r) ##1 (sync2_r && !filt_r)[*3]
         |=> filt_r;
   endproperty
   a_filter_delay: assert property (p_filter_delay)
      else $error("filtered level not high four cycles after input");

endmodule

// *** src/tfg_pkg.sv ***
/*
 package for the timer fault guard and wide register access block:
 cpu register indices, control field positions, reset values and widths.
 assumes an 8-bit cpu bus with a small register address.
*/
package tfg_pkg;

   // ==========================================================
   // widths
   // ==========================================================
   localparam int ADDR_W   = 3;             // register address width
   localparam int DATA_W   = 8;             // cpu data width
   localparam int WIDE_W   = 10;            // counter and compare width
   localparam int HOLD_W   = 2;             // shared high bits holder
   localparam int N_CMP    = 4;             // compare registers a..d
   localparam int N_PINS   = 4;             // guarded pwm pins
   localparam int FILT_LEN = 4;             // samples that must agree

   // ==========================================================
   // register indices
   // ==========================================================
   localparam logic [2:0] REG_HOLD  = 3'h0; // timer_wide_high_bits_hold
   localparam logic [2:0] REG_COUNT = 3'h1; // timer_count_value low byte
   localparam logic [2:0] REG_CMP_A = 3'h2; // compare a low byte, b..d follow
   localparam logic [2:0] REG_CTRL  = 3'h6; // timer_ctrl_reg_d fault fields
   localparam logic [2:0] REG_MODE  = 3'h7; // output_mode_bits, two per pin

   // ==========================================================
   // timer_ctrl_reg_d field positions
   // ==========================================================
   localparam int CTRL_EN     = 0;          // fault_guard_enable
   localparam int CTRL_IRQ_EN = 1;          // fault_guard_irq_enable
   localparam int CTRL_SRC    = 2;          // fault_source_comparator_select
   localparam int CTRL_FILT   = 3;          // fault_filter_enable
   localparam int CTRL_RISE   = 4;          // edge select, 1 = rising
   localparam int CTRL_FLAG   = 5;          // fault_event_flag, write 1 clears

   // ==========================================================
   // reset values
   // ==========================================================
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [1:0] HOLD_RESET = 2'h0;
   localparam logic [9:0] WIDE_RESET = 10'h000;

endpackage

// *** src/tfg_top.sv ***
/*
 timer fault guard with 10-bit register access over an 8-bit cpu port.
 holds the counter, four compare registers, the shared high bits
 holder, the fault control fields and the output mode pairs.
 assumes synchronous pins, a timer tick enable from the prescaler and
 waveform bits from the waveform generator outside.
*/
//
// Behaviour
// - system clock only, tick is an enable
// - enabled qualifying edge enters fault protection
// - fault clears mode pairs, pins follow port
// - enable cleared with mode bits same cycle
// - irq enable set raises fault interrupt
// - source is pin, or comparator when selected
// - both sources share sampler and edge detector
// - port-driven pin level triggers like external
// - filter output changes after four equal samples
// - filter adds four clock cycles delay
// - filter samples system clock, ignores prescaler
// - wide registers share one 2-bit holder
// - low byte write loads holder plus byte
// - low byte read copies high bits to holder
`timescale 1ns/100ps
module tfg_top
   import tfg_pkg::*;
(
   // clock and reset
   input  wire logic              clock_in,
   input  wire logic              reset_in,
   // cpu register port
   input  wire logic [ADDR_W-1:0] cpu_addr_in,
   input  wire logic              cpu_wr_in,
   input  wire logic              cpu_rd_in,
   input  wire logic [DATA_W-1:0] cpu_wdata_in,
   output logic      [DATA_W-1:0] cpu_rdata_out,
   // timer side
   input  wire logic              timer_tick_enable_in,
   input  wire logic [N_PINS-1:0] waveform_in,
   input  wire logic [N_PINS-1:0] port_output_latch_in,
   output logic      [WIDE_W-1:0] timer_count_value_out,
   output logic      [N_PINS-1:0] pwm_pins_out,
   // fault sources and request
   input  wire logic              ext_irq_pin_zero_in,
   input  wire logic              comparator_output_in,
   output logic                   fault_irq_out
);

   // ==========================================================
   // storage
   // ==========================================================
   logic [HOLD_W-1:0] hold_r;                 // timer_wide_high_bits_hold
   logic [WIDE_W-1:0] count_r;                // timer_count_value
   logic [WIDE_W-1:0] cmp_r [N_CMP];          // compare_value_regs
   logic [7:0]        ctrl_r;                 // timer_ctrl_reg_d fields
   logic [7:0]        mode_r;                 // output_mode_bits pairs
   logic              fault_hit;              // enabled event this cycle
   logic              wr_ctrl;                // cpu write to control
   tfg_fault_if       fault_if ();

   // index of a compare register, or N_CMP when not one
   function automatic int cmp_index(input logic [ADDR_W-1:0] a);
      int idx;
      idx = N_CMP;
      if (a >= REG_CMP_A && a < REG_CMP_A + 3'(N_CMP))
      begin
         idx = int'(a - REG_CMP_A);
      end
      return idx;
   endfunction

   // ==========================================================
   // fault path
   // ==========================================================
   // pin level already carries any port-driven value
   assign fault_if.raw_level = ctrl_r[CTRL_SRC] ? comparator_output_in
                                                : ext_irq_pin_zero_in;
   assign fault_if.filt_en   = ctrl_r[CTRL_FILT];
   assign fault_if.rise_sel  = ctrl_r[CTRL_RISE];
   assign fault_hit          = ctrl_r[CTRL_EN] && fault_if.event_hit;
   assign wr_ctrl            = cpu_wr_in && cpu_addr_in == REG_CTRL;

   // shared sampler for either source
   tfg_fault_sampler tfg_fault_sampler_inst
   (
      .clock_in (clock_in),
      .reset_in (reset_in),
      .fault_if (fault_if.smp)
   );

   // control fields, flag set wins over write-one clear
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         ctrl_r <= CTRL_RESET;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_r[4:0] <= cpu_wdata_in[4:0];
            if (cpu_wdata_in[CTRL_FLAG])
            begin
               ctrl_r[CTRL_FLAG] <= 1'b0;
            end
         end
         if (fault_hit)
         begin
            ctrl_r[CTRL_EN]   <= 1'b0;
            ctrl_r[CTRL_FLAG] <= 1'b1;
         end
      end
   end

   // output mode pairs, wiped by a fault in the same cycle
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         mode_r <= MODE_RESET;
      end
      else if (fault_hit)
      begin
         mode_r <= MODE_RESET;
      end
      else if (cpu_wr_in && cpu_addr_in == REG_MODE)
      begin
         mode_r <= cpu_wdata_in;
      end
   end

   // pins follow waveform only while their mode pair is non-zero
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         pwm_pins_out <= '0;
      end
      else
      begin
         for (int i = 0; i < N_PINS; i++)
         begin
            pwm_pins_out[i] <= (mode_r[2*i +: 2] != 2'b00) ? waveform_in[i]
                                                           : port_output_latch_in[i];
         end
      end
   end

   // interrupt request while flag and its enable are both set
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         fault_irq_out <= 1'b0;
      end
      else
      begin
         fault_irq_out <= ctrl_r[CTRL_FLAG] && ctrl_r[CTRL_IRQ_EN];
      end
   end

   // ==========================================================
   // wide registers
   // ==========================================================
   // holder: direct write, or high bits of a low byte read
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         hold_r <= HOLD_RESET;
      end
      else if (cpu_wr_in && cpu_addr_in == REG_HOLD)
      begin
         hold_r <= cpu_wdata_in[HOLD_W-1:0];
      end
      else if (cpu_rd_in && cpu_addr_in == REG_COUNT)
      begin
         hold_r <= count_r[WIDE_W-1:DATA_W];
      end
      else if (cpu_rd_in && cmp_index(cpu_addr_in) < N_CMP)
      begin
         hold_r <= cmp_r[cmp_index(cpu_addr_in)][WIDE_W-1:DATA_W];
      end
   end

   // counter: cpu write first, else count on the tick enable
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         count_r <= WIDE_RESET;
      end
      else if (cpu_wr_in && cpu_addr_in == REG_COUNT)
      begin
         count_r <= {hold_r, cpu_wdata_in};
      end
      else if (timer_tick_enable_in)
      begin
         count_r <= count_r + 10'h001;
      end
   end

   // compare registers loaded as a whole on low byte write
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         for (int i = 0; i < N_CMP; i++)
         begin
            cmp_r[i] <= WIDE_RESET;
         end
      end
      else if (cpu_wr_in && cmp_index(cpu_addr_in) < N_CMP)
      begin
         cmp_r[cmp_index(cpu_addr_in)] <= {hold_r, cpu_wdata_in};
      end
   end

   // read data captured on the read strobe, unmapped reads zero
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         cpu_rdata_out <= 8'h00;
      end
      else if (cpu_rd_in)
      begin
         case (cpu_addr_in)
            REG_HOLD:  cpu_rdata_out <= {6'h00, hold_r};
            REG_COUNT: cpu_rdata_out <= count_r[DATA_W-1:0];
            REG_CTRL:  cpu_rdata_out <= ctrl_r; // enable polling
            REG_MODE:  cpu_rdata_out <= mode_r;
            default:
            begin
               if (cmp_index(cpu_addr_in) < N_CMP)
               begin
                  cpu_rdata_out <= cmp_r[cmp_index(cpu_addr_in)][DATA_W-1:0];
               end
               else
               begin
                  cpu_rdata_out <= 8'h00;
               end
            end
         endcase
      end
   end

   // count seen by the waveform logic outside
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         timer_count_value_out <= WIDE_RESET;
      end
      else
      begin
         timer_count_value_out <= count_r;
      end
   end

   // ==========================================================
   // assertions
   // ==========================================================
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);

   property p_fault_enter;
      fault_hit |=> mode_r == 8'h00 && !ctrl_r[CTRL_EN] && ctrl_r[CTRL_FLAG];
   endproperty
   a_fault_enter: assert property (p_fault_enter)
      else $error("fault did not clear modes and enable");

   property p_clear_together;
      $fell(ctrl_r[CTRL_EN]) && !$past(wr_ctrl) |-> mode_r == 8'h00;
   endproperty
   a_clear_together: assert property (p_clear_together)
      else $error("enable cleared without mode bits");

   property p_pins_port;
      fault_hit ##1 !(cpu_wr_in && cpu_addr_in == REG_MODE)
         |=> pwm_pins_out == $past(port_output_latch_in);
   endproperty
   a_pins_port: assert property (p_pins_port)
      else $error("pins not driven from port after fault");

   property p_irq;
      fault_hit && ctrl_r[CTRL_IRQ_EN] && !wr_ctrl |=> ##1 fault_irq_out;
   endproperty
   a_irq: assert property (p_irq)
      else $error("fault interrupt not raised");

   property p_tick_only;
      !timer_tick_enable_in && !(cpu_wr_in && cpu_addr_in == REG_COUNT) |=> $stable(count_r);
   endproperty
   a_tick_only: assert property (p_tick_only)
      else $error("counter moved without tick");

   property p_wide_write;
      cpu_wr_in && cpu_addr_in == REG_COUNT |=> count_r == {$past(hold_r), $past(cpu_wdata_in)};
   endproperty
   a_wide_write: assert property (p_wide_write)
      else $error("low byte write did not load holder bits");

   property p_wide_read;
      cpu_rd_in && !cpu_wr_in && cpu_addr_in == REG_CMP_A
         |=> hold_r == $past(cmp_r[0][WIDE_W-1:DATA_W]);
   endproperty
   a_wide_read: assert property (p_wide_read)
      else $error("low byte read did not copy high bits");

   property p_hold_keep;
      !cpu_wr_in && !cpu_rd_in |=> $stable(hold_r);
   endproperty
   a_hold_keep: assert property (p_hold_keep)
      else $error("holder changed without access");

endmodule

// *** testbench/tfg_far_model.sv ***
/*
 far side model for the timer fault guard: the fault pin and the
 comparator, plus the waveform generator and port latch bits.
 assumes the bench commands the fault levels just after a clock edge.
*/
`timescale 1ns/100ps
module tfg_far_model
   import tfg_pkg::*;
(
   // commanded levels
   input  wire logic              pin_cmd_in,
   input  wire logic              cmp_cmd_in,
   // levels toward the block
   output logic                   ext_irq_pin_zero_out,
   output logic                   comparator_output_out,
   output logic      [N_PINS-1:0] waveform_out,
   output logic      [N_PINS-1:0] port_output_latch_out
);
   // ==========================================================
   // sources
   // ==========================================================
   // software drive of the pin port lands on the pin itself
   assign ext_irq_pin_zero_out  = pin_cmd_in;
   // comparator level as commanded
   assign comparator_output_out = cmp_cmd_in;
   // distinct patterns so the pin mux choice is visible
   assign waveform_out          = 4'hA;
   assign port_output_latch_out = 4'h5;
endmodule

// *** testbench/tfg_top_test.sv ***
/*
 self-checking bench for the timer fault guard and wide access block.
 assumes the register map of tfg_pkg and the block's register latencies.
*/
`timescale 1ns/100ps
module tfg_top_test;
   import tfg_pkg::*;

   // ==========================================================
   // signals
   // ==========================================================
   logic              clock_in;  // system clock
   logic              reset_in;  // synchronous reset
   logic [ADDR_W-1:0] cpu_addr;  // register index
   logic              cpu_wr;    // write strobe
   logic              cpu_rd;    // read strobe
   logic [DATA_W-1:0] cpu_wdata; // write data
   logic [DATA_W-1:0] cpu_rdata; // read data
   logic              tick;      // timer tick enable
   logic [N_PINS-1:0] wave;      // waveform bits
   logic [N_PINS-1:0] port;      // port latch bits
   logic [WIDE_W-1:0] count;     // counter copy
   logic [N_PINS-1:0] pins;      // guarded pins
   logic              pin_lvl;   // fault pin
   logic              cmp_lvl;   // comparator level
   logic              pin_cmd;   // commanded pin level
   logic              cmp_cmd;   // commanded comparator level
   logic              irq;       // fault request
   int                fails;       // mismatches
   int                checks_done; // comparisons
   int                cycles;      // timeout counter

   // ==========================================================
   // instances
   // ==========================================================
   tfg_top tfg_top_inst
   (
      .clock_in              (clock_in),
      .reset_in              (reset_in),
      .cpu_addr_in           (cpu_addr),
      .cpu_wr_in             (cpu_wr),
      .cpu_rd_in             (cpu_rd),
      .cpu_wdata_in          (cpu_wdata),
      .cpu_rdata_out         (cpu_rdata),
      .timer_tick_enable_in  (tick),
      .waveform_in           (wave),
      .port_output_latch_in  (port),
      .timer_count_value_out (count),
      .pwm_pins_out          (pins),
      .ext_irq_pin_zero_in   (pin_lvl),
      .comparator_output_in  (cmp_lvl),
      .fault_irq_out         (irq)
   );
   tfg_far_model tfg_far_model_inst
   (
      .pin_cmd_in            (pin_cmd),
      .cmp_cmd_in            (cmp_cmd),
      .ext_irq_pin_zero_out  (pin_lvl),
      .comparator_output_out (cmp_lvl),
      .waveform_out          (wave),
      .port_output_latch_out (port)
   );

   // ==========================================================
   // clock and timeout
   // ==========================================================
   // 200 MHz system clock
   initial
   begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   // cut a hang short
   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         summarize();
      end
   end

   // ==========================================================
   // helpers
   // ==========================================================
   // compare and count
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one bus cycle, strobes held until the next call or idle
   task automatic acc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
      cpu_wr    = w;
      cpu_rd    = r;
      cpu_addr  = a;
      cpu_wdata = d;
      @(posedge clock_in);
      #1;
   endtask
   // release strobes and let n edges pass
   task automatic idle(input int n);
      cpu_wr = 1'b0;
      cpu_rd = 1'b0;
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      acc(1'b1, 1'b0, a, d);
   endtask
   // read data is there just after the edge that samples the read strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
      acc(1'b0, 1'b1, a, 8'h00);
      chk(what, {2'h0, exp}, {2'h0, cpu_rdata});
   endtask
   // drive the chosen fault source
   task automatic set_sel(input logic src, input logic v);
      if (src)
         cmp_cmd = v;
      else
         pin_cmd = v;
   endtask

   // ==========================================================
   // scenarios
   // ==========================================================
   // reset values and pin default
   task automatic test_reset;
      rd(REG_CTRL, CTRL_RESET, "ctrl_reset");
      rd(REG_MODE, MODE_RESET, "mode_reset");
      rd(REG_HOLD, {6'h00, HOLD_RESET}, "hold_reset");
      rd(REG_COUNT, 8'h00, "count_reset");
      chk("pins_reset", {6'h00, port}, {6'h00, pins});
      wr(REG_CTRL, 8'hC0);
      rd(REG_CTRL, 8'h00, "ctrl_top_bits");
      idle(1);
   endtask
   // wide access through the shared holder
   task automatic test_wide;
      wr(REG_HOLD, 8'hFE);
      rd(REG_HOLD, 8'h02, "hold_width");
      wr(REG_HOLD, 8'h01);
      wr(REG_COUNT, 8'hFF);
      idle(2);
      chk("count_out", 10'h1FF, count);
      wr(REG_HOLD, 8'h02);
      rd(REG_COUNT, 8'hFF, "count_low");
      rd(REG_HOLD, 8'h01, "count_high");
      for (int i = 0; i < N_CMP; i++)
      begin
         wr(REG_HOLD, 8'(i));
         wr(REG_CMP_A + 3'(i), 8'h10 + 8'(i));
      end
      wr(REG_HOLD, 8'h03);
      for (int i = 0; i < N_CMP; i++)
      begin
         rd(REG_CMP_A + 3'(i), 8'h10 + 8'(i), "cmp_low");
         rd(REG_MODE, 8'h00, "mode_between");
         rd(REG_HOLD, 8'(i), "cmp_high");
      end
      idle(1);
   endtask
   // tick is a plain enable on the system clock, counter wraps
   task automatic test_tick;
      wr(REG_HOLD, 8'h03);
      wr(REG_COUNT, 8'hFE);
      tick = 1'b1;
      idle(5);
      tick = 1'b0;
      idle(1);
      rd(REG_COUNT, 8'h03, "count_ticked");
      rd(REG_HOLD, 8'h00, "count_wrapped");
      idle(1);
   endtask
   // one fault trigger with a given source, edge, filter, irq enable
   task automatic fault_case(input logic src, input logic rise, input logic filt, input logic ie);
      logic [7:0] cfg;
      cfg     = {3'b000, rise, filt, src, ie, 1'b0};
      pin_cmd = ~rise;
      cmp_cmd = ~rise;
      wr(REG_MODE, 8'hFF);
      wr(REG_CTRL, cfg);
      idle(12);
      wr(REG_CTRL, cfg | 8'h21);
      idle(2);
      chk("pins_armed", {6'h00, wave}, {6'h00, pins});
      set_sel(~src, rise);
      idle(12);
      chk("irq_unselected", 10'h000, {9'h000, irq});
      rd(REG_CTRL, cfg | 8'h01, "ctrl_unselected");
      if (filt)
      begin
         set_sel(src, rise);
         idle(3);
         set_sel(src, ~rise);
         idle(12);
         chk("irq_glitch", 10'h000, {9'h000, irq});
         rd(REG_CTRL, cfg | 8'h01, "ctrl_glitch");
      end
      idle(1);
      set_sel(src, rise);
      idle(3 + 4 * int'(filt));
      chk("pins_before", {6'h00, wave}, {6'h00, pins});
      chk("irq_before", 10'h000, {9'h000, irq});
      idle(1);
      chk("pins_fault", {6'h00, port}, {6'h00, pins});
      chk("irq_fault", {9'h000, ie}, {9'h000, irq});
      rd(REG_CTRL, cfg | 8'h20, "ctrl_fault");
      rd(REG_MODE, 8'h00, "mode_fault");
      wr(REG_CTRL, cfg | 8'h20);
      idle(3);
      chk("irq_cleared", 10'h000, {9'h000, irq});
      rd(REG_CTRL, cfg, "ctrl_cleared");
      idle(1);
   endtask

   // ==========================================================
   // closing report
   // ==========================================================
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   // ==========================================================
   // irq enable follows src xnor edge, so each source is run with it both set and clear
   initial
   begin
      fails       = 0;
      checks_done = 0;
      cycles      = 0;
      reset_in    = 1'b1;
      cpu_addr    = 3'h0;
      cpu_wr      = 1'b0;
      cpu_rd      = 1'b0;
      cpu_wdata   = 8'h00;
      tick        = 1'b0;
      pin_cmd     = 1'b0;
      cmp_cmd     = 1'b0;
      repeat (5) @(posedge clock_in);
      #1;
      reset_in = 1'b0;
      test_reset();
      test_wide();
      test_tick();
      // filter runs with the tick held low
      for (int i = 0; i < 8; i++)
         fault_case(i[0], i[1], i[2], ~(i[0] ^ i[1]));
      summarize();
   end
endmodule
